// file: emf_mac.sv
// Purpose: ethernet frame-field engine, transmit framing and receive parsing
// Assumes: phy side and client side are logic on CORE_CLK_I, one byte a cycle
// Notes:   the phy serialiser sends each byte lsb first; the client keeps
//          TX_VALID_I high through a frame
`timescale 1ns/100ps
`include "emf_map.svh"

module emf_mac
  import emf_pkg::*;
(
  input  wire logic           CORE_CLK_I,
  input  wire logic           NRST_I,
  input  wire logic           CUSTOM_PRE_I,
  input  wire logic           TX_FCS_INBAND_I,
  input  wire logic           RX_FCS_PASS_I,
  input  wire logic           RX_LEN_CHECK_I,
  input  wire logic           RX_VLAN_EN_I,
  input  wire logic           RX_JUMBO_EN_I,
  input  wire logic [7:0]     TX_DATA_I,
  input  wire logic           TX_VALID_I,
  input  wire logic           TX_LAST_I,
  output logic                TX_READY_O,
  output emf_addr_kind_t      TX_ADDR_KIND_O,
  output logic [7:0]          PHY_TXD_O,
  output logic                PHY_TXEN_O,
  input  wire logic [7:0]     PHY_RXD_I,
  input  wire logic           PHY_RXDV_I,
  output logic [7:0]          RX_DATA_O,
  output logic                RX_VALID_O,
  output logic                RX_END_O,
  output logic                RX_GOOD_O,
  output logic                RX_FCS_ERR_O,
  output logic                RX_LEN_ERR_O,
  output logic                RX_SIZE_ERR_O,
  output emf_addr_kind_t      RX_ADDR_KIND_O,
  output logic                RX_IS_TYPE_O,
  output logic                RX_VLAN_O,
  output logic                RX_PAUSE_O
);

  // --------------------------------------------------------------------------
  // crc helper
  // --------------------------------------------------------------------------
  // one byte through the reflected crc, bit 0 first as on the wire
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ `EMF_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_byte

  // --------------------------------------------------------------------------
  // transmit path
  // --------------------------------------------------------------------------
  emf_tx_state_t  tx_st_q;
  logic [15:0]    tx_cnt_q;
  logic [15:0]    tx_cnt_d;
  logic [1:0]     tx_fcnt_q;
  logic [31:0]    tx_crc_q;
  logic [31:0]    tx_fcs;
  logic           tx_take;
  logic           tx_mc_q;
  logic           tx_bc_q;

  assign tx_take  = TX_VALID_I && TX_READY_O;
  assign tx_cnt_d = (tx_cnt_q == `EMF_CNT_MAX) ? tx_cnt_q : tx_cnt_q + 16'h0001;
  assign tx_fcs   = ~tx_crc_q;

  // framing sequencer; the line byte and enable are registered here
  always_ff @(posedge CORE_CLK_I) begin
    if (!NRST_I) begin
      tx_st_q    <= TX_IDLE;
      tx_cnt_q   <= 16'h0000;
      tx_fcnt_q  <= 2'h0;
      tx_crc_q   <= `EMF_CRC_INIT;
      TX_READY_O <= 1'b0;
      PHY_TXD_O  <= 8'h00;
      PHY_TXEN_O <= 1'b0;
    end else begin
      unique case (tx_st_q)
        TX_IDLE: begin
          PHY_TXD_O  <= 8'h00;
          PHY_TXEN_O <= 1'b0;
          if (TX_VALID_I) begin
            PHY_TXD_O  <= `EMF_PRE_BYTE;                          // [R1]
            PHY_TXEN_O <= 1'b1;
            tx_cnt_q   <= 16'h0001;
            tx_crc_q   <= `EMF_CRC_INIT;
            tx_st_q    <= TX_PRE;
          end
        end
        TX_PRE: begin
          if (tx_cnt_q == `EMF_PRE_LEN) begin
            // custom mode takes the client's first byte in the delimiter slot
            PHY_TXD_O  <= tx_take ? TX_DATA_I : `EMF_SFD_BYTE;  // [R3] [R5]
            tx_cnt_q   <= 16'h0000;
            TX_READY_O <= 1'b1;
            tx_st_q    <= TX_DATA;
          end else begin
            PHY_TXD_O <= `EMF_PRE_BYTE;                           // [R1]
            tx_cnt_q  <= tx_cnt_d;
            if (tx_cnt_q == `EMF_PRE_LEN - 16'h0001) begin
              TX_READY_O <= CUSTOM_PRE_I;                         // [R5]
            end
          end
        end
        TX_DATA: begin
          if (tx_take) begin
            // client bytes, addresses and length/type included, go out as given
            PHY_TXD_O  <= TX_DATA_I;                              // [R8] [R9] [R12] [R23]
            PHY_TXEN_O <= 1'b1;
            tx_crc_q   <= crc_byte(tx_crc_q, TX_DATA_I);
            tx_cnt_q   <= tx_cnt_d;
            if (TX_LAST_I) begin
              TX_READY_O <= 1'b0;
              tx_fcnt_q  <= 2'h0;
              if (TX_FCS_INBAND_I) begin
                tx_st_q <= TX_GAP;                                // [R19]
              end else if (tx_cnt_d < `EMF_MIN_NOFCS) begin
                tx_st_q <= TX_PAD;                                // [R18]
              end else begin
                tx_st_q <= TX_FCS;
              end
            end
          end else begin
            // client underrun: line enable drops, nothing is invented
            PHY_TXEN_O <= 1'b0;
          end
        end
        TX_PAD: begin
          PHY_TXD_O  <= `EMF_PAD_BYTE;                            // [R24]
          PHY_TXEN_O <= 1'b1;
          tx_crc_q   <= crc_byte(tx_crc_q, `EMF_PAD_BYTE);        // [R20]
          tx_cnt_q   <= tx_cnt_d;
          if (tx_cnt_d == `EMF_MIN_NOFCS) begin
            tx_st_q <= TX_FCS;                                    // [R18] [R19]
          end
        end
        TX_FCS: begin
          PHY_TXD_O  <= tx_fcs[{tx_fcnt_q, 3'b000} +: 8];         // [R19]
          PHY_TXEN_O <= 1'b1;
          tx_fcnt_q  <= tx_fcnt_q + 2'h1;
          if (tx_fcnt_q == `EMF_FCS_LAST) begin
            tx_st_q <= TX_GAP;
          end
        end
        TX_GAP: begin
          // at least one dead cycle so two frames never merge
          PHY_TXD_O  <= 8'h00;
          PHY_TXEN_O <= 1'b0;
          tx_st_q    <= TX_IDLE;
        end
        default: begin
          tx_st_q <= TX_IDLE;
        end
      endcase
    end
  end

  // destination address class of the frame being sent
  always_ff @(posedge CORE_CLK_I) begin
    if (!NRST_I) begin
      tx_mc_q        <= 1'b0;
      tx_bc_q        <= 1'b0;
      TX_ADDR_KIND_O <= EMF_UNICAST;
    end else begin
      if (tx_st_q == TX_DATA && tx_take && tx_cnt_q < `EMF_ADDR_LEN) begin
        if (tx_cnt_q == 16'h0000) begin
          tx_mc_q <= TX_DATA_I[0];                                // [R6] [R7]
          tx_bc_q <= (TX_DATA_I == `EMF_ALL_ONES);
        end else begin
          tx_bc_q <= tx_bc_q && (TX_DATA_I == `EMF_ALL_ONES);
        end
      end
      TX_ADDR_KIND_O <= tx_bc_q ? EMF_BROADCAST :
                        (tx_mc_q ? EMF_MULTICAST : EMF_UNICAST);  // [R6]
    end
  end

  // --------------------------------------------------------------------------
  // receive path
  // --------------------------------------------------------------------------
  emf_rx_state_t  rx_st_q;
  logic [15:0]    rx_pcnt_q;
  logic [15:0]    rx_idx_q;
  logic [15:0]    rx_idx_d;
  logic [15:0]    rx_lt_q;
  logic [31:0]    rx_crc_q;
  logic [7:0]     rx_sh_q [4];
  logic [1:0]     rx_fcnt_q;
  logic           rx_mc_q;
  logic           rx_bc_q;
  logic           rx_is_len;
  logic           rx_keep;
  logic [15:0]    rx_max;
  logic           rx_len_bad;
  logic           rx_size_bad;
  logic           rx_short;

  assign rx_idx_d  = (rx_idx_q == `EMF_CNT_MAX) ? rx_idx_q : rx_idx_q + 16'h0001;
  assign rx_is_len = (rx_lt_q < `EMF_TYPE_MIN);                   // [R10]
  // byte leaving the delay line is kept unless it is length-frame pad and fcs passthrough is off
  assign rx_keep   = RX_FCS_PASS_I || !rx_is_len
                     || (rx_idx_q < rx_lt_q + `EMF_HDR_FCS);      // [R13] [R21]
  assign rx_max    = `EMF_MAX_FRAME + ((RX_VLAN_EN_I && rx_lt_q == `EMF_LT_VLAN) ?
                     `EMF_VLAN_EXTRA : 16'h0000);                 // [R16]
  assign rx_short  = (rx_idx_q < `EMF_MIN_FRAME);
  // short length fields must come with exactly the minimum frame
  assign rx_len_bad = RX_LEN_CHECK_I && rx_is_len &&
                      ((rx_lt_q < `EMF_DATA_MIN) ? (rx_idx_q != `EMF_MIN_FRAME)
                       : (rx_idx_q != rx_lt_q + `EMF_HDR_FCS));   // [R14]
  assign rx_size_bad = rx_short || (!RX_JUMBO_EN_I && rx_idx_q > rx_max); // [R17]

  // parser: preamble, body through a four byte delay, flush, end report
  always_ff @(posedge CORE_CLK_I) begin
    if (!NRST_I) begin
      rx_st_q    <= RX_IDLE;
      rx_pcnt_q  <= 16'h0000;
      rx_idx_q   <= 16'h0000;
      rx_lt_q    <= `EMF_CNT_MAX;
      rx_crc_q   <= `EMF_CRC_INIT;
      rx_fcnt_q  <= 2'h0;
      rx_sh_q    <= '{default: 8'h00};
      RX_DATA_O  <= 8'h00;
      RX_VALID_O <= 1'b0;
      RX_END_O   <= 1'b0;
    end else begin
      RX_VALID_O <= 1'b0;
      RX_END_O   <= 1'b0;
      unique case (rx_st_q)
        RX_IDLE: begin
          rx_idx_q <= 16'h0000;
          rx_lt_q  <= `EMF_CNT_MAX;
          rx_crc_q <= `EMF_CRC_INIT;
          if (PHY_RXDV_I) begin
            rx_pcnt_q <= 16'h0001;
            if (CUSTOM_PRE_I) begin
              RX_DATA_O  <= PHY_RXD_I;                            // [R2]
              RX_VALID_O <= 1'b1;
              rx_st_q    <= RX_PRE;
            end else if (PHY_RXD_I == `EMF_SFD_BYTE) begin
              rx_st_q <= RX_BODY;                                 // [R4]
            end else if (PHY_RXD_I == `EMF_PRE_BYTE) begin
              rx_st_q <= RX_PRE;                                  // [R2]
            end else begin
              rx_st_q <= RX_DROP;
            end
          end
        end
        RX_PRE: begin
          if (!PHY_RXDV_I) begin
            rx_st_q <= RX_IDLE;
          end else if (CUSTOM_PRE_I) begin
            // delimiter slot is dropped without looking at its value
            if (rx_pcnt_q == `EMF_PRE_LEN) begin
              rx_st_q <= RX_BODY;                                 // [R4] [R5]
            end else begin
              RX_DATA_O  <= PHY_RXD_I;                            // [R2]
              RX_VALID_O <= 1'b1;
              rx_pcnt_q  <= rx_pcnt_q + 16'h0001;
            end
          end else if (PHY_RXD_I == `EMF_SFD_BYTE) begin
            rx_st_q <= RX_BODY;                                   // [R4]
          end else if (PHY_RXD_I != `EMF_PRE_BYTE) begin
            rx_st_q <= RX_DROP;
          end
        end
        RX_BODY: begin
          if (PHY_RXDV_I) begin
            rx_sh_q  <= '{rx_sh_q[1], rx_sh_q[2], rx_sh_q[3], PHY_RXD_I};
            rx_crc_q <= crc_byte(rx_crc_q, PHY_RXD_I);            // [R22]
            rx_idx_q <= rx_idx_d;
            if (rx_idx_q == `EMF_LT_HI_POS) begin
              rx_lt_q[15:8] <= PHY_RXD_I;
            end
            if (rx_idx_q == `EMF_LT_LO_POS) begin
              rx_lt_q[7:0] <= PHY_RXD_I;
            end
            // da, sa and length/type all leave the delay line in order
            if (rx_idx_q >= `EMF_RX_DELAY && rx_keep) begin
              RX_DATA_O  <= rx_sh_q[0];                           // [R8] [R9] [R15]
              RX_VALID_O <= 1'b1;
            end
          end else begin
            rx_fcnt_q <= 2'h0;
            rx_st_q   <= RX_FCS_PASS_I ? RX_FLUSH : RX_DONE;
          end
        end
        RX_FLUSH: begin
          // the held bytes are the fcs; delivered only in passthrough mode
          rx_sh_q   <= '{rx_sh_q[1], rx_sh_q[2], rx_sh_q[3], 8'h00};
          rx_fcnt_q <= rx_fcnt_q + 2'h1;
          if ({14'h0000, rx_fcnt_q} + rx_idx_q >= `EMF_RX_DELAY) begin
            RX_DATA_O  <= rx_sh_q[0];                             // [R21]
            RX_VALID_O <= 1'b1;
          end
          if (rx_fcnt_q == `EMF_FCS_LAST) begin
            rx_st_q <= RX_DONE;
          end
        end
        RX_DONE: begin
          RX_END_O <= 1'b1;
          rx_st_q  <= RX_IDLE;
        end
        RX_DROP: begin
          if (!PHY_RXDV_I) begin
            rx_st_q <= RX_IDLE;
          end
        end
        default: begin
          rx_st_q <= RX_IDLE;
        end
      endcase
    end
  end

  // frame status, stable from the end report until the next frame ends
  always_ff @(posedge CORE_CLK_I) begin
    if (!NRST_I) begin
      RX_GOOD_O     <= 1'b0;
      RX_FCS_ERR_O  <= 1'b0;
      RX_LEN_ERR_O  <= 1'b0;
      RX_SIZE_ERR_O <= 1'b0;
      RX_IS_TYPE_O  <= 1'b0;
      RX_VLAN_O     <= 1'b0;
      RX_PAUSE_O    <= 1'b0;
    end else if (rx_st_q == RX_DONE) begin
      RX_FCS_ERR_O  <= (rx_crc_q != `EMF_CRC_RESID);              // [R22]
      RX_LEN_ERR_O  <= rx_len_bad;                                // [R14]
      RX_SIZE_ERR_O <= rx_size_bad;                               // [R16] [R17]
      RX_GOOD_O     <= (rx_crc_q == `EMF_CRC_RESID) && !rx_len_bad && !rx_size_bad;
      RX_IS_TYPE_O  <= !rx_is_len;                                // [R10] [R15]
      RX_VLAN_O     <= (rx_lt_q == `EMF_LT_VLAN);                 // [R11]
      RX_PAUSE_O    <= (rx_lt_q == `EMF_LT_PAUSE);                // [R11]
    end
  end

  // destination address class of the frame being received
  always_ff @(posedge CORE_CLK_I) begin
    if (!NRST_I) begin
      rx_mc_q        <= 1'b0;
      rx_bc_q        <= 1'b0;
      RX_ADDR_KIND_O <= EMF_UNICAST;
    end else begin
      if (rx_st_q == RX_BODY && PHY_RXDV_I && rx_idx_q < `EMF_ADDR_LEN) begin
        if (rx_idx_q == 16'h0000) begin
          rx_mc_q <= PHY_RXD_I[0];                                // [R6] [R7]
          rx_bc_q <= (PHY_RXD_I == `EMF_ALL_ONES);
        end else begin
          rx_bc_q <= rx_bc_q && (PHY_RXD_I == `EMF_ALL_ONES);
        end
      end
      if (rx_st_q == RX_DONE) begin
        RX_ADDR_KIND_O <= rx_bc_q ? EMF_BROADCAST :
                          (rx_mc_q ? EMF_MULTICAST : EMF_UNICAST); // [R6]
      end
    end
  end

endmodule : emf_mac

// file: emf_mac_properties.sv
// Purpose: concurrent checks on the frame-field engine ports
// Assumes: one clock, synchronous active-low reset
// Notes:   mode inputs are held steady while a frame is in flight
`timescale 1ns/100ps
module emf_mac_checker (
  input wire logic       CORE_CLK_I,
  input wire logic       NRST_I,
  input wire logic       CUSTOM_PRE_I,
  input wire logic       RX_FCS_PASS_I,
  input wire logic [7:0] TX_DATA_I,
  input wire logic       TX_VALID_I,
  input wire logic       TX_READY_O,
  input wire logic [7:0] PHY_TXD_O,
  input wire logic       PHY_TXEN_O,
  input wire logic       PHY_RXDV_I,
  input wire logic       RX_END_O,
  input wire logic       RX_GOOD_O,
  input wire logic       RX_FCS_ERR_O,
  input wire logic       RX_LEN_ERR_O,
  input wire logic       RX_SIZE_ERR_O,
  input wire logic       RX_IS_TYPE_O,
  input wire logic       RX_VLAN_O,
  input wire logic       RX_PAUSE_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!NRST_I);

  // ---------------------------------------------------------------------------
  // transmit framing
  // ---------------------------------------------------------------------------
  a_pre_seven_bytes: assert property (
    $rose(PHY_TXEN_O) |-> (PHY_TXEN_O && PHY_TXD_O == 8'h55) [*7])
    else $error("preamble is not seven fill bytes");
  a_sfd_follows: assert property (
    $rose(PHY_TXEN_O) && !CUSTOM_PRE_I |-> ##7 PHY_TXD_O == 8'hd5)
    else $error("delimiter missing after preamble");
  // custom mode opens the client one byte early so it can own the delimiter
  a_ready_opens: assert property (
    $rose(PHY_TXEN_O) |-> ##6 (TX_READY_O == CUSTOM_PRE_I))
    else $error("client opened at the wrong byte");
  a_tx_passes: assert property (
    TX_VALID_I && TX_READY_O |=> PHY_TXEN_O && PHY_TXD_O == $past(TX_DATA_I))
    else $error("taken byte not sent unchanged next cycle");

  // ---------------------------------------------------------------------------
  // receive status
  // ---------------------------------------------------------------------------
  a_end_delay: assert property (
    $fell(PHY_RXDV_I) |-> ##2 (RX_END_O ^ RX_FCS_PASS_I) ##4 (RX_END_O == RX_FCS_PASS_I))
    else $error("frame end pulse at wrong distance");
  a_good_means: assert property (
    RX_END_O |-> RX_GOOD_O == !(RX_FCS_ERR_O || RX_LEN_ERR_O || RX_SIZE_ERR_O))
    else $error("good flag disagrees with error flags");
  a_codes_typed: assert property (
    RX_END_O && (RX_VLAN_O || RX_PAUSE_O) |-> RX_IS_TYPE_O)
    else $error("vlan or pause code not seen as type");
  a_status_hold: assert property (
    !RX_END_O |-> $stable({RX_GOOD_O, RX_FCS_ERR_O, RX_LEN_ERR_O, RX_SIZE_ERR_O,
                           RX_IS_TYPE_O, RX_VLAN_O, RX_PAUSE_O}))
    else $error("status moved between frame ends");

  c_good_frame: cover property (RX_END_O && RX_GOOD_O);
  c_vlan_frame: cover property (RX_END_O && RX_VLAN_O && RX_GOOD_O);
  c_fcs_bad:    cover property (RX_END_O && RX_FCS_ERR_O);
endmodule : emf_mac_checker

bind emf_mac emf_mac_checker u_chk (.CORE_CLK_I, .NRST_I, .CUSTOM_PRE_I, .RX_FCS_PASS_I,
  .TX_DATA_I, .TX_VALID_I, .TX_READY_O, .PHY_TXD_O, .PHY_TXEN_O, .PHY_RXDV_I, .RX_END_O,
  .RX_GOOD_O, .RX_FCS_ERR_O, .RX_LEN_ERR_O, .RX_SIZE_ERR_O, .RX_IS_TYPE_O, .RX_VLAN_O,
  .RX_PAUSE_O);

// file: emf_map.svh
// Purpose: constants of the frame-field engine: bytes, field offsets, lengths
// Assumes: byte-wide streams, one byte per CORE_CLK_I cycle
// Notes:   counters are 16 bits wide and saturate, so long frames never wrap
//
// Contract
// [R1] tx sends seven 0x55 preamble bytes itself
// [R2] rx strips preamble unless custom preamble mode
// [R3] tx inserts delimiter byte d5 after preamble
// [R4] rx always discards the delimiter byte
// [R5] custom mode: client delimiter, rx unchecked
// [R6] classify unicast, multicast, broadcast destination address
// [R7] address bytes go out lsb first
// [R8] destination address leads tx and rx data
// [R9] source address second, forwarded unchanged
// [R10] length/type 1536 or more means type
// [R11] 0x8100 means vlan, 0x8808 means pause
// [R12] tx length/type passes untouched
// [R13] rx length field strips the pad
// [R14] length check flags mismatch when enabled
// [R15] type passes unprocessed, field always delivered
// [R16] vlan acceptance allows four extra bytes
// [R17] data 0..1500 bytes, jumbo never truncated
// [R18] pad data to 46, frame to 64
// [R19] mac pad implies mac fcs; bit selects
// [R20] pad in fcs, not in length
// [R21] rx drops pad unless fcs passthrough
// [R22] rx checks fcs, flags bad frames
// [R23] client lane order da, sa, length/type
// [R24] inserted pad bytes are zero
`ifndef EMF_MAP_SVH
`define EMF_MAP_SVH

// ----------------------------------------------------------------------------
// fixed bytes and field positions
// ----------------------------------------------------------------------------
`define EMF_PRE_BYTE   8'h55
`define EMF_SFD_BYTE   8'hd5
`define EMF_PAD_BYTE   8'h00
`define EMF_ALL_ONES   8'hff
`define EMF_PRE_LEN    16'h0007
`define EMF_ADDR_LEN   16'h0006
`define EMF_LT_HI_POS  16'h000c
`define EMF_LT_LO_POS  16'h000d
`define EMF_RX_DELAY   16'h0004
`define EMF_FCS_LAST   2'h3

// ----------------------------------------------------------------------------
// lengths and length/type codes
// ----------------------------------------------------------------------------
`define EMF_MIN_NOFCS  16'h003c
`define EMF_MIN_FRAME  16'h0040
`define EMF_MAX_FRAME  16'h05ee
`define EMF_VLAN_EXTRA 16'h0004
`define EMF_HDR_FCS    16'h0012
`define EMF_DATA_MIN   16'h002e
`define EMF_TYPE_MIN   16'h0600
`define EMF_LT_VLAN    16'h8100
`define EMF_LT_PAUSE   16'h8808
`define EMF_CNT_MAX    16'hffff

// ----------------------------------------------------------------------------
// fcs crc, bit-reflected form
// ----------------------------------------------------------------------------
`define EMF_CRC_POLY   32'hedb88320
`define EMF_CRC_INIT   32'hffffffff
`define EMF_CRC_RESID  32'hdebb20e3

`endif

// file: emf_phy_model.sv
// Purpose: line-side partner, loops transmitted bytes back into the receiver
// Assumes: same clock as the engine, one byte per cycle
// Notes:   one byte of a frame can be inverted on command to spoil the fcs
`timescale 1ns/100ps
module emf_phy_model (
  input  wire logic        clk_i,
  input  wire logic [7:0]  txd_i,
  input  wire logic        txen_i,
  input  wire logic [15:0] flip_at_i,
  output logic [7:0]       rxd_o,
  output logic             rxdv_o
);
  logic [15:0] idx_q;

  // ---------------------------------------------------------------------------
  // loopback with one cycle of line delay
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    rxdv_o <= txen_i;
    idx_q  <= txen_i ? idx_q + 16'h0001 : 16'h0000;
    if (txen_i) begin
      rxd_o <= (idx_q == flip_at_i) ? ~txd_i : txd_i;
    end else begin
      rxd_o <= (rxd_o === 8'haa) ? 8'h55 : 8'haa;  // idle line churns, no stale byte
    end
  end
endmodule : emf_phy_model

// file: emf_pkg.sv
// Purpose: types shared by the frame-field engine
// Assumes: nothing
// Notes:   state codes are left to the tools
package emf_pkg;

  typedef enum logic [1:0] {EMF_UNICAST, EMF_MULTICAST, EMF_BROADCAST} emf_addr_kind_t;

  typedef enum logic [2:0] {TX_IDLE, TX_PRE, TX_DATA, TX_PAD, TX_FCS, TX_GAP} emf_tx_state_t;

  typedef enum logic [2:0] {RX_IDLE, RX_PRE, RX_BODY, RX_DROP, RX_FLUSH,
                            RX_DONE} emf_rx_state_t;

endpackage : emf_pkg

// file: tb.sv
// Purpose: self-checking bench, client frames looped through the line model
// Assumes: inputs change at the falling edge
// Notes:   receive checks rely on the loopback carrying the engine's own fcs
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
  $display("Error %0t: got %0h want %0h", $time, (g), (e)); end end
module tb;
  import emf_pkg::*;
  typedef struct {logic [7:0] da; logic [15:0] lt; int n; logic jb;
                  emf_addr_kind_t kd; logic [5:0] st;} emf_row_t;
  logic clk, nrst, cpre, inband, fpass, lchk, vlan, jumbo, txv, txl, tx_rdy, ptxen, prxdv;
  logic rxv, rx_end, good, fcs_err, len_err, size_err, is_type, is_vlan, is_pause;
  logic [7:0]     txd, ptxd, prxd, rxd;
  logic [15:0]    flip;
  emf_addr_kind_t tx_kind, rx_kind;
  logic [7:0]     fr [$], line [$], rxq [$];
  int             num_errors = 0, n_compared = 0, ends = 0, b, mx;
  // status bits: type, vlan, pause, length error, size error, good
  emf_row_t rows [9] = '{'{8'h02, 16'h002e, 46, 1'b0, EMF_UNICAST, 6'h01},
    '{8'h01, 16'h0800, 50, 1'b0, EMF_MULTICAST, 6'h21}, '{8'hff, 16'h8808, 46, 1'b0,
    EMF_BROADCAST, 6'h29}, '{8'h03, 16'h0005, 5, 1'b0, EMF_MULTICAST, 6'h01},
    '{8'h02, 16'h8100, 1504, 1'b0, EMF_UNICAST, 6'h31}, '{8'h02, 16'h0800, 1504, 1'b0,
    EMF_UNICAST, 6'h22}, '{8'h02, 16'h0040, 60, 1'b0, EMF_UNICAST, 6'h04},
    '{8'h02, 16'h05ff, 1535, 1'b1, EMF_UNICAST, 6'h01}, '{8'h02, 16'h0600, 1600, 1'b1,
    EMF_UNICAST, 6'h21}};

  emf_mac DUT (.CORE_CLK_I(clk), .NRST_I(nrst), .CUSTOM_PRE_I(cpre), .TX_FCS_INBAND_I(inband),
    .RX_FCS_PASS_I(fpass), .RX_LEN_CHECK_I(lchk), .RX_VLAN_EN_I(vlan), .RX_JUMBO_EN_I(jumbo),
    .TX_DATA_I(txd), .TX_VALID_I(txv), .TX_LAST_I(txl), .TX_READY_O(tx_rdy),
    .TX_ADDR_KIND_O(tx_kind), .PHY_TXD_O(ptxd), .PHY_TXEN_O(ptxen), .PHY_RXD_I(prxd),
    .PHY_RXDV_I(prxdv), .RX_DATA_O(rxd), .RX_VALID_O(rxv), .RX_END_O(rx_end),
    .RX_GOOD_O(good), .RX_FCS_ERR_O(fcs_err), .RX_LEN_ERR_O(len_err),
    .RX_SIZE_ERR_O(size_err), .RX_ADDR_KIND_O(rx_kind), .RX_IS_TYPE_O(is_type),
    .RX_VLAN_O(is_vlan), .RX_PAUSE_O(is_pause));
  emf_phy_model u_phy (.clk_i(clk), .txd_i(ptxd), .txen_i(ptxen), .flip_at_i(flip),
    .rxd_o(prxd), .rxdv_o(prxdv));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ---------------------------------------------------------------------------
  // monitors and tasks
  // ---------------------------------------------------------------------------
  always @(posedge clk) begin
    if (ptxen) line.push_back(ptxd);
    if (rxv) rxq.push_back(rxd);
    if (rx_end) ends++;
  end

  task automatic tally_and_finish();
    if (num_errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish

  // da six times, sa, length/type high byte first, then nonzero data
  task automatic build(input logic [7:0] da, input logic [15:0] lt, input int n);
    fr.delete();
    repeat (6) fr.push_back(da);
    for (int i = 0; i < 6; i++) fr.push_back(8'ha0 + 8'(i));
    fr.push_back(lt[15:8]);
    fr.push_back(lt[7:0]);
    for (int i = 0; i < n; i++) fr.push_back(8'h80 | 8'(i));
  endtask : build

  // valid held through the frame; a byte counts as taken when ready is high
  task automatic run();
    int k, t;
    line.delete();
    rxq.delete();
    k = 0;
    t = 0;
    txv = 1'b1;
    txd = fr[0];
    while (k < fr.size()) begin
      @(posedge clk);
      t++;
      if (tx_rdy === 1'b1) k++;
      @(negedge clk);
      if (k < fr.size()) txd = fr[k];
      txl = (k == fr.size() - 1);
      if (t > 4000) begin num_errors++; tally_and_finish(); end
    end
    txv = 1'b0;
    t = ends;
    for (int w = 0; w < 4000 && ends == t; w++) @(negedge clk);
    if (ends == t) begin num_errors++; tally_and_finish(); end
    repeat (8) @(negedge clk);  // far end owes at least seven idle cycles
  endtask : run

  task automatic check_line(input int tot, input int m);
    int o;
    o = cpre ? 7 : 8;
    `CHK(line.size(), tot)
    for (int i = 0; i < o + m; i++) begin
      if (i < 7) `CHK(line[i], 8'h55)
      else if (i < o) `CHK(line[i], 8'hd5)
      else `CHK(line[i], (i - o < fr.size()) ? fr[i - o] : 8'h00)
    end
  endtask : check_line

  // ---------------------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------------------
  initial begin
    {cpre, inband, fpass, jumbo, txv, txl} = 6'h00;
    {lchk, vlan, nrst} = 3'h6;
    txd = 8'h00;
    flip = 16'hffff;
    repeat (8) @(negedge clk);
    `CHK({ptxen, tx_rdy, rxv, rx_end, good}, 5'h00)
    nrst = 1'b1;
    foreach (rows[j]) begin
      jumbo = rows[j].jb;
      build(rows[j].da, rows[j].lt, rows[j].n);
      run();
      b = 14 + rows[j].n;
      mx = (b < 60) ? 60 : b;
      check_line(mx + 12, mx);
      `CHK({is_type, is_vlan, is_pause, len_err, size_err, good}, rows[j].st)
      `CHK(rx_kind, rows[j].kd)
      `CHK(tx_kind, rows[j].kd)
      if (rows[j].st[2:1] == 2'h0) begin
        b = rows[j].st[5] ? mx : 14 + int'(rows[j].lt);
        `CHK(rxq.size(), b)
        for (int i = 0; i < b; i++) `CHK(rxq[i], fr[i])
      end
    end
    // passthrough hands pad and fcs to the client
    fpass = 1'b1;
    build(8'h02, 16'h0005, 5);
    run();
    `CHK(rxq.size(), 64)
    for (int i = 19; i < 60; i++) `CHK(rxq[i], 8'h00)
    fpass = 1'b0;
    // one spoilt pad byte on the line must fail the check
    flip = 16'h001e;
    run();
    `CHK({fcs_err, good}, 2'h2)
    flip = 16'hffff;
    // client owns pad and fcs: short frame goes out bare
    inband = 1'b1;
    repeat (4) fr.push_back(8'h00);
    run();
    check_line(31, 23);
    `CHK({size_err, good}, 2'h2)
    inband = 1'b0;
    // custom mode: client delimiter out, preamble kept on receive
    cpre = 1'b1;
    build(8'h02, 16'h002e, 46);
    fr.push_front(8'ha7);
    run();
    check_line(72, 61);
    `CHK(rxq[6], 8'h55)
    `CHK(rxq[7], 8'h02)
    `CHK(good, 1'b1)
    cpre = 1'b0;
    // checks off: length mismatch ignored, tagged frame held to the normal maximum
    {lchk, vlan, jumbo} = 3'h0;
    build(8'h02, 16'h0040, 60);
    run();
    `CHK({len_err, good}, 2'h1)
    build(8'h02, 16'h8100, 1504);
    run();
    `CHK({size_err, good}, 2'h2)
    // reset after the last frame clears the held status and both address classes
    nrst = 1'b0;
    @(negedge clk);
    `CHK({size_err, good, rx_kind, tx_kind}, 6'h00)
    nrst = 1'b1;
    tally_and_finish();
  end
endmodule : tb
